/* hw/mucd_pkg.sv */
// constants shared by the command-done interrupt block
// Overview of operation
// - A slot's raw done bit sets when the command launched through that slot finishes.
// - Raw done bit 0 belongs to slot 0 and bit 1 to slot 1, in the two low bits.
// - Writing 1 to a raw done bit clears it; writing 0 leaves it alone.
// - A masked done bit reads 1 only while its raw bit and its enable bit are both 1.
// - Masked bit 0 belongs to slot 0 and masked bit 1 to slot 1.
// - Writing 1 to a masked bit clears that slot's indication; writing 0 does nothing.
// - Writing 1 to an enable-set bit enables the done interrupt of that slot.
// - A slot with enable 0 never interrupts, and the enable-set register reads back the enables.
// - Writing 0 to an enable-set bit leaves the stored enable unchanged.
// - Writing 1 to an enable-clear bit disables that slot; writing 0 does nothing.
// - A slot's launch bit clears itself when its access finishes, the same event that sets raw.
package mucd_pkg;
    localparam int SLOTS = 2;
    // register byte offsets
    localparam logic [31:0] OFF_RAW = 32'h0000_0000;
    localparam logic [31:0] OFF_MASKED = 32'h0000_0004;
    localparam logic [31:0] OFF_EN_SET = 32'h0000_0008;
    localparam logic [31:0] OFF_EN_CLR = 32'h0000_000c;
    localparam logic [31:0] OFF_SLOT0 = 32'h0000_0010;
    localparam logic [31:0] OFF_SLOT1 = 32'h0000_0014;
    // internal register select codes
    localparam logic [2:0] SEL_RAW = 3'h0;
    localparam logic [2:0] SEL_MASKED = 3'h1;
    localparam logic [2:0] SEL_EN_SET = 3'h2;
    localparam logic [2:0] SEL_EN_CLR = 3'h3;
    localparam logic [2:0] SEL_SLOT0 = 3'h4;
    localparam logic [2:0] SEL_SLOT1 = 3'h5;
    // field positions and reset values
    localparam int GO_BIT = 31;
    localparam logic [1:0] RAW_RST = 2'h0;
    localparam logic [1:0] EN_RST = 2'h0;
    localparam logic [31:0] SLOT_RST = 32'h0000_0000;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* hw/mucd_irq.sv */
// command-done events, enables, launch slots and axi4-lite slave
//
// The AXI4-Lite interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
module mucd_irq (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // axi4-lite write address
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    // axi4-lite write data
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // axi4-lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // axi4-lite read address
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    // axi4-lite read data
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // access state machine side
    output logic [1:0] slotGo,
    output logic [30:0] slot0Cmd,
    output logic [30:0] slot1Cmd,
    input wire logic [1:0] slotDone,
    // interrupt toward the host
    output logic cmdDoneIrq
);

    typedef struct packed {
        logic awRdy;
        logic awHeld;
        logic [3:0] awSel;
        logic wRdy;
        logic wHeld;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic bValid;
        logic [1:0] bResp;
        logic arRdy;
        logic rValid;
        logic [1:0] rResp;
        logic [31:0] rData;
        logic [1:0] raw;
        logic [1:0] en;
        logic [1:0][31:0] slot;
        logic irq;
    } mucd_state_s;

    mucd_state_s st_q;
    mucd_state_s st_d;

    logic commit;
    logic wrOk;
    logic [2:0] wrSel;
    logic [1:0] lowBits;
    logic [1:0] doneHit;
    logic [1:0] rawClr;
    logic [1:0] enSet;
    logic [1:0] enClr;
    logic [1:0] slotWr;
    logic [1:0] maskedNow;
    logic arTake;
    logic [3:0] arSel;

    // address decode: {mapped, select}; the protection bits are not checked
    function automatic logic [3:0] decode(input logic [31:0] addr);
        logic [3:0] r;
        r = 4'h0;
        case (addr)
            mucd_pkg::OFF_RAW: r = {1'b1, mucd_pkg::SEL_RAW};
            mucd_pkg::OFF_MASKED: r = {1'b1, mucd_pkg::SEL_MASKED};
            mucd_pkg::OFF_EN_SET: r = {1'b1, mucd_pkg::SEL_EN_SET};
            mucd_pkg::OFF_EN_CLR: r = {1'b1, mucd_pkg::SEL_EN_CLR};
            mucd_pkg::OFF_SLOT0: r = {1'b1, mucd_pkg::SEL_SLOT0};
            mucd_pkg::OFF_SLOT1: r = {1'b1, mucd_pkg::SEL_SLOT1};
            default: r = 4'h0;
        endcase
        return r;
    endfunction

    // write side effects, computed once address and data are both held
    assign commit = st_q.awHeld && st_q.wHeld;
    assign wrOk = commit && st_q.awSel[3];
    assign wrSel = st_q.awSel[2:0];
    assign lowBits = st_q.wStrb[0] ? st_q.wData[1:0] : 2'h0;
    // a finish only counts for a slot that was really launched
    assign doneHit = slotDone & {st_q.slot[1][mucd_pkg::GO_BIT], st_q.slot[0][mucd_pkg::GO_BIT]};
    assign rawClr = (wrOk && (wrSel == mucd_pkg::SEL_RAW || wrSel == mucd_pkg::SEL_MASKED))
        ? lowBits : 2'h0;
    assign enSet = (wrOk && wrSel == mucd_pkg::SEL_EN_SET) ? lowBits : 2'h0;
    assign enClr = (wrOk && wrSel == mucd_pkg::SEL_EN_CLR) ? lowBits : 2'h0;
    assign maskedNow = st_q.raw & st_q.en;
    assign arTake = st_q.arRdy && s_axi_arvalid;
    assign arSel = decode(s_axi_araddr);

    // slot writes are locked out while that slot's launch is pending
    genvar gi;
    generate
        for (gi = 0; gi < mucd_pkg::SLOTS; gi++) begin : gSlot
            assign slotWr[gi] = wrOk && wrSel == (mucd_pkg::SEL_SLOT0 + 3'(gi))
                && !st_q.slot[gi][mucd_pkg::GO_BIT];
        end
    endgenerate

    // next state of everything
    always_comb begin
        st_d = st_q;
        // write address channel
        if (st_q.awRdy && s_axi_awvalid) begin
            st_d.awRdy = 1'b0;
            st_d.awHeld = 1'b1;
            st_d.awSel = decode(s_axi_awaddr);
        end
        // write data channel, independent of address order
        if (st_q.wRdy && s_axi_wvalid) begin
            st_d.wRdy = 1'b0;
            st_d.wHeld = 1'b1;
            st_d.wData = s_axi_wdata;
            st_d.wStrb = s_axi_wstrb;
        end
        // both halves present: act and answer
        if (commit) begin
            st_d.awHeld = 1'b0;
            st_d.wHeld = 1'b0;
            st_d.bValid = 1'b1;
            st_d.bResp = st_q.awSel[3] ? mucd_pkg::RESP_OKAY : mucd_pkg::RESP_SLVERR;
        end
        // readies come back only after the response is taken
        if (st_q.bValid && s_axi_bready) begin
            st_d.bValid = 1'b0;
            st_d.awRdy = 1'b1;
            st_d.wRdy = 1'b1;
        end
        // event bits: a finish in the clearing cycle survives
        st_d.raw = (st_q.raw & ~rawClr) | doneHit;
        st_d.en = (st_q.en | enSet) & ~enClr;
        // slot words merge by byte lane; launch bit is write-one-to-set
        for (int i = 0; i < mucd_pkg::SLOTS; i++) begin
            if (slotWr[i]) begin
                for (int b = 0; b < 3; b++) begin
                    if (st_q.wStrb[b]) begin
                        st_d.slot[i][b*8 +: 8] = st_q.wData[b*8 +: 8];
                    end
                end
                if (st_q.wStrb[3]) begin
                    st_d.slot[i][30:24] = st_q.wData[30:24];
                    st_d.slot[i][mucd_pkg::GO_BIT] = st_q.wData[mucd_pkg::GO_BIT];
                end
            end
            if (doneHit[i]) begin
                st_d.slot[i][mucd_pkg::GO_BIT] = 1'b0;
            end
        end
        // interrupt follows the next masked state, so it lines up with it
        st_d.irq = |(st_d.raw & st_d.en);
        // read channel answers one cycle after the address
        if (arTake) begin
            st_d.arRdy = 1'b0;
            st_d.rValid = 1'b1;
            st_d.rResp = arSel[3] ? mucd_pkg::RESP_OKAY : mucd_pkg::RESP_SLVERR;
            case (arSel)
                {1'b1, mucd_pkg::SEL_RAW}: st_d.rData = {30'h0, st_q.raw};
                {1'b1, mucd_pkg::SEL_MASKED}: st_d.rData = {30'h0, maskedNow};
                {1'b1, mucd_pkg::SEL_EN_SET}: st_d.rData = {30'h0, st_q.en};
                {1'b1, mucd_pkg::SEL_EN_CLR}: st_d.rData = {30'h0, st_q.en};
                {1'b1, mucd_pkg::SEL_SLOT0}: st_d.rData = st_q.slot[0];
                {1'b1, mucd_pkg::SEL_SLOT1}: st_d.rData = st_q.slot[1];
                default: st_d.rData = 32'h0;
            endcase
        end
        if (st_q.rValid && s_axi_rready) begin
            st_d.rValid = 1'b0;
            st_d.arRdy = 1'b1;
        end
    end

    // state register; readies sit high from reset on
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st_q <= '0;
            st_q.awRdy <= 1'b1;
            st_q.wRdy <= 1'b1;
            st_q.arRdy <= 1'b1;
            st_q.raw <= mucd_pkg::RAW_RST;
            st_q.en <= mucd_pkg::EN_RST;
            st_q.slot <= {mucd_pkg::SLOT_RST, mucd_pkg::SLOT_RST};
        end else begin
            st_q <= st_d;
        end
    end

    // outputs straight from the state register
    assign s_axi_awready = st_q.awRdy;
    assign s_axi_wready = st_q.wRdy;
    assign s_axi_bvalid = st_q.bValid;
    assign s_axi_bresp = st_q.bResp;
    assign s_axi_arready = st_q.arRdy;
    assign s_axi_rvalid = st_q.rValid;
    assign s_axi_rdata = st_q.rData;
    assign s_axi_rresp = st_q.rResp;
    assign slotGo = {st_q.slot[1][mucd_pkg::GO_BIT], st_q.slot[0][mucd_pkg::GO_BIT]};
    assign slot0Cmd = st_q.slot[0][30:0];
    assign slot1Cmd = st_q.slot[1][30:0];
    assign cmdDoneIrq = st_q.irq;

    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    // raw event bits: set by a counted finish, cleared only by a write of one
    raw_set_a: assert property (doneHit != 2'h0
        |=> (st_q.raw & $past(doneHit)) == $past(doneHit))
        else $error("raw bit not set by finish");
    raw_lane_a: assert property (slotDone == 2'h1 && slotGo == 2'h1 && st_q.raw == 2'h0
        && rawClr == 2'h0 |=> st_q.raw == 2'h1)
        else $error("slot 0 finish set wrong raw bit");
    raw_clear_a: assert property ((rawClr & ~doneHit) != 2'h0
        |=> (st_q.raw & $past(rawClr & ~doneHit)) == 2'h0)
        else $error("raw bit not cleared by write one");
    raw_keep_a: assert property (##1
        (($past(st_q.raw) & ~st_q.raw & ~$past(rawClr)) == 2'h0))
        else $error("raw bit fell without a clear");
    masked_read_a: assert property (arTake && arSel == {1'b1, mucd_pkg::SEL_MASKED}
        |=> s_axi_rvalid && s_axi_rdata == {30'h0, $past(maskedNow)})
        else $error("masked read differs from raw and enable");
    // masked writes clear the raw bit of the lane written, and only that lane
    masked_clr_a: assert property (wrOk && wrSel == mucd_pkg::SEL_MASKED && lowBits[1]
        && !doneHit[1] |=> !st_q.raw[1]
        && st_q.raw[0] == $past((st_q.raw[0] & ~lowBits[0]) | doneHit[0]))
        else $error("masked write cleared the wrong slot");

    // enables: set and cleared only by writing one, read back on both addresses
    en_set_a: assert property (enSet != 2'h0 |=> (st_q.en & $past(enSet)) == $past(enSet))
        else $error("enable not set");
    en_clr_a: assert property (enClr != 2'h0 |=> (st_q.en & $past(enClr)) == 2'h0)
        else $error("enable not cleared");
    en_keep_a: assert property (##1
        ((($past(st_q.en) ^ st_q.en) & ~($past(enSet) | $past(enClr))) == 2'h0))
        else $error("enable changed without a write one");
    en_read_a: assert property (arTake && arSel == {1'b1, mucd_pkg::SEL_EN_SET}
        |=> s_axi_rdata == {30'h0, $past(st_q.en)})
        else $error("enable-set read wrong");
    go_clear_a: assert property (doneHit[0] |=> !slotGo[0] && st_q.raw[0])
        else $error("launch bit not cleared on finish");

    // interrupt level follows the masked bits with no extra lag
    irq_level_a: assert property (cmdDoneIrq == |(st_q.raw & st_q.en))
        else $error("interrupt out of step with masked bits");
    irq_off_a: assert property (st_q.en == 2'h0 |-> !cmdDoneIrq)
        else $error("interrupt while all slots disabled");
    irq_rise_a: assert property ((doneHit & st_q.en) != 2'h0 |=> cmdDoneIrq)
        else $error("enabled finish raised no interrupt");

    // second lane, launch bit and reserved bits
    raw_lane1_a: assert property (doneHit == 2'h2 && rawClr == 2'h0
        |=> st_q.raw[1] && st_q.raw[0] == $past(st_q.raw[0]))
        else $error("slot 1 finish set wrong raw bit");
    go_clear1_a: assert property (doneHit[1] |=> !slotGo[1] && st_q.raw[1])
        else $error("slot 1 launch bit not cleared on finish");
    go_set_a: assert property (wrOk && wrSel == mucd_pkg::SEL_SLOT1 && !slotGo[1]
        && st_q.wStrb[3] && st_q.wData[mucd_pkg::GO_BIT] |=> slotGo[1])
        else $error("launch bit not set by write");
    resv_zero_a: assert property (arTake && arSel[3] && arSel[2:0] < mucd_pkg::SEL_SLOT0
        |=> s_axi_rdata[31:2] == 30'h0)
        else $error("reserved read bits not zero");
    slot_lock_a: assert property (slotGo[0] && !doneHit[0]
        |=> $stable(st_q.slot[0]))
        else $error("slot word changed while launch pending");

    // one transfer at a time per direction; refused addresses answer an error
    one_wr_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write readies high while response pending");
    one_rd_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read ready high while data pending");
    ready_back_a: assert property (s_axi_bvalid && s_axi_bready
        |=> s_axi_awready && s_axi_wready && !s_axi_bvalid)
        else $error("write readies not back after response");
    bad_wr_a: assert property (commit && !st_q.awSel[3]
        |=> s_axi_bresp == mucd_pkg::RESP_SLVERR && $stable(st_q.en))
        else $error("unmapped write not refused");
    bad_rd_a: assert property (arTake && !arSel[3]
        |=> s_axi_rresp == mucd_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    clr_read_a: assert property (arTake && arSel == {1'b1, mucd_pkg::SEL_EN_CLR}
        |=> s_axi_rdata == {30'h0, $past(st_q.en)})
        else $error("enable-clear read wrong");

    // main scenarios worth seeing
    done_seen_c: cover property (doneHit != 2'h0 ##1 cmdDoneIrq);
    both_slots_c: cover property (st_q.raw == 2'h3 && st_q.en == 2'h3);
    clr_race_c: cover property ((rawClr & doneHit) != 2'h0);
    bad_addr_c: cover property (s_axi_bvalid && s_axi_bresp == mucd_pkg::RESP_SLVERR);
    lock_out_c: cover property (wrOk && wrSel == mucd_pkg::SEL_SLOT0 && slotGo[0]);

endmodule // mucd_irq

/* sim/mucd_phy_model.sv */
// behavioural access state machine that answers the launch bits
`timescale 1ns/100ps
module mucd_phy_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // launch bits and completion pulses
    input wire logic [1:0] slotGo,
    input wire logic [7:0] lat,
    output logic [1:0] slotDone
);
    logic [7:0] cnt [2];
    // one pulse per launch, lat+1 cycles after the launch bit rises; no pulse while the done is still seen
    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < 2; i++) begin
            slotDone[i] <= 1'b0;
            cnt[i] <= 8'h00;
            if (!srst && slotGo[i] && !slotDone[i]) begin
                if (cnt[i] == lat) begin
                    slotDone[i] <= 1'b1;
                end else begin
                    cnt[i] <= cnt[i] + 8'h01;
                end
            end
        end
    end
endmodule // mucd_phy_model

/* sim/tb_mucd_irq.sv */
// self-checking bench for the command-done interrupt block
`timescale 1ns/100ps
module tb_mucd_irq;
    logic sys_clk = 1'b0, srst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid, irq;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
    logic [1:0] bresp, rresp, slotGo, slotDone;
    logic [30:0] cmd0, cmd1;
    logic [7:0] lat = 8'h03;
    int fails = 0, samplesChecked = 0, cycles = 0;
    localparam logic [1:0] OK = mucd_pkg::RESP_OKAY;
    localparam logic [1:0] ERR = mucd_pkg::RESP_SLVERR;
    always #50 sys_clk = ~sys_clk;
    mucd_irq uut (.sys_clk(sys_clk), .srst(srst), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .slotGo(slotGo),
        .slot0Cmd(cmd0), .slot1Cmd(cmd1), .slotDone(slotDone), .cmdDoneIrq(irq));
    mucd_phy_model phy (.sys_clk(sys_clk), .srst(srst), .slotGo(slotGo), .lat(lat),
        .slotDone(slotDone));
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samplesChecked, fails);
        if (fails == 0 && samplesChecked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // a hang ends the run through the same report
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 4000) begin
            fails++;
            wrap_up();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samplesChecked++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            fails++;
        end
    endtask
    // both write channels offered together, each released when taken
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge sys_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        chk($sformatf("bresp %h", a), {30'h0, er}, {30'h0, bresp});
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge sys_clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        chk($sformatf("rdata %h", a), ed, rdata);
        chk($sformatf("rresp %h", a), {30'h0, er}, {30'h0, rresp});
        @(posedge sys_clk);
    endtask
    // launch a slot and wait until its go bit has cleared itself
    task automatic launch(input int s, input logic [31:0] c);
        wr(s == 0 ? mucd_pkg::OFF_SLOT0 : mucd_pkg::OFF_SLOT1, 32'h8000_0000 | c, OK);
        while (slotGo[s] !== 1'b0) @(posedge sys_clk);
    endtask
    task automatic t_reset();
        for (int i = 0; i < 4; i++) rd(i * 4, 32'h0, OK);
        chk("irq", 32'h0, {31'h0, irq});
        chk("slotGo", 32'h0, {30'h0, slotGo});
    endtask
    task automatic t_events();
        launch(0, 32'h0000_1234);
        rd(mucd_pkg::OFF_RAW, 32'h1, OK);
        rd(mucd_pkg::OFF_SLOT0, 32'h0000_1234, OK);
        chk("slot0Cmd", 32'h0000_1234, {1'b0, cmd0});
        lat <= 8'h14;
        launch(1, 32'h0000_0077);
        chk("slot1Cmd", 32'h0000_0077, {1'b0, cmd1});
        rd(mucd_pkg::OFF_RAW, 32'h3, OK);
        rd(mucd_pkg::OFF_MASKED, 32'h0, OK);
        chk("irq", 32'h0, {31'h0, irq});
        wr(mucd_pkg::OFF_RAW, 32'h0, OK);
        rd(mucd_pkg::OFF_RAW, 32'h3, OK);
        wr(mucd_pkg::OFF_RAW, 32'h1, OK);
        rd(mucd_pkg::OFF_RAW, 32'h2, OK);
    endtask
    task automatic t_enables();
        wr(mucd_pkg::OFF_EN_SET, 32'h1, OK);
        rd(mucd_pkg::OFF_EN_SET, 32'h1, OK);
        rd(mucd_pkg::OFF_MASKED, 32'h0, OK);
        wr(mucd_pkg::OFF_EN_SET, 32'h0, OK);
        rd(mucd_pkg::OFF_EN_SET, 32'h1, OK);
        wr(mucd_pkg::OFF_EN_SET, 32'h2, OK);
        rd(mucd_pkg::OFF_MASKED, 32'h2, OK);
        chk("irq", 32'h1, {31'h0, irq});
        wr(mucd_pkg::OFF_MASKED, 32'h0, OK);
        rd(mucd_pkg::OFF_MASKED, 32'h2, OK);
        wr(mucd_pkg::OFF_MASKED, 32'h2, OK);
        rd(mucd_pkg::OFF_RAW, 32'h0, OK);
        chk("irq", 32'h0, {31'h0, irq});
    endtask
    task automatic t_disable();
        wr(mucd_pkg::OFF_EN_CLR, 32'h0, OK);
        rd(mucd_pkg::OFF_EN_SET, 32'h3, OK);
        wr(mucd_pkg::OFF_EN_CLR, 32'h1, OK);
        rd(mucd_pkg::OFF_EN_SET, 32'h2, OK);
        lat <= 8'h28;
        wr(mucd_pkg::OFF_SLOT0, 32'h8000_00aa, OK);
        wr(mucd_pkg::OFF_SLOT0, 32'h0000_0055, OK);
        rd(mucd_pkg::OFF_SLOT0, 32'h8000_00aa, OK);
        while (slotGo[0] !== 1'b0) @(posedge sys_clk);
        rd(mucd_pkg::OFF_SLOT0, 32'h0000_00aa, OK);
        rd(mucd_pkg::OFF_RAW, 32'h1, OK);
        rd(mucd_pkg::OFF_MASKED, 32'h0, OK);
        chk("irq", 32'h0, {31'h0, irq});
        launch(1, 32'h0000_0033);
        chk("irq", 32'h1, {31'h0, irq});
        wr(mucd_pkg::OFF_RAW, 32'h2, OK);
        chk("irq", 32'h0, {31'h0, irq});
        wr(32'h0000_0040, 32'h1, ERR);
        rd(32'h0000_0040, 32'h0, ERR);
    endtask
    // reset for two cycles, then the scenarios in turn
    initial begin
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        t_reset();
        t_events();
        t_enables();
        t_disable();
        wrap_up();
    end
endmodule // tb_mucd_irq
